// ### hdl/qdac_dev.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Twelve-bit words arrive most significant bit first
// - Data sampled on each serial clock rise
// - Clock edges ignored while chip select high
// - Only last twelve bits decoded, surplus dropped
// - Byte master sends two right-justified bytes
// - Chip select rise writes addressed channel register
// - Shutdown word still loads data, output held
// - Both shutdown bits active shut every channel
// - One software shutdown bit disables only the selected channel
// - DAC registers ignore loads while in shutdown, but clear still zeroes them
// - Clear zeroes all input and DAC registers
// - Load strobe copies inputs to DACs of channels not in shutdown
// - Load strobe low makes DAC registers transparent
// - Unused clear tied high, load tied low
// - Power-down request tristates all four outputs
// - Reset zeroes all input and DAC registers
// - DAC codes stay zero until a load
// - Four eight-bit codes, output is ref*code/256
module qdac_dev (
  // Clock, reset, enable
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // Serial link
  qdac_if.device                    link,
  // Channel codes and output enables
  output qdac_pkg::qdac_code_t      dacCode,
  output qdac_pkg::qdac_code_t      inputCode,
  output logic [qdac_pkg::NUM_CH-1:0] analogOutEn,
  // Status
  output logic [qdac_pkg::NUM_CH-1:0] swShutdown,
  output logic                      hwShutdown,
  output qdac_pkg::qdac_word_t      lastWord,
  output logic                      wordStrobe,
  output logic                      shortFrame
);
  import qdac_pkg::*;

  function automatic logic [NUM_CH-1:0] chanOneHot(input qdac_word_t w);
    logic [NUM_CH-1:0] oh;
    oh = '0;
    oh[{w[SEL_HI_POS], w[SEL_LO_POS]}] = 1'b1;
    return oh;
  endfunction

  logic [SY_W-1:0]   pinIn;
  logic [SY_W-1:0]   syncA_q;
  logic [SY_W-1:0]   syncB_q;
  logic              sclkPrev_q;
  logic              csPrev_q;
  logic              sclkRise;
  logic              csRise;
  logic              csLow;
  logic              clearNow;
  logic              loadLow;
  qdac_word_t        shift_q;
  logic [CNT_W-1:0]  bitCnt_q;
  logic              wordOk;
  logic [NUM_CH-1:0] target;
  logic              sdFirstOn;
  logic              sdSecondOn;
  qdac_code_t        inReg_q;
  qdac_code_t        dacReg_q;
  logic [NUM_CH-1:0] swShut_q;
  logic [NUM_CH-1:0] anyShut;
  qdac_word_t        lastWord_q;
  logic              wordStrobe_q;
  logic              shortFrame_q;

  assign pinIn[SY_SCLK] = link.sclk;
  assign pinIn[SY_CS]   = link.csN;
  assign pinIn[SY_SDI]  = link.sdi;
  assign pinIn[SY_PDR]  = link.powerDownReq;
  assign pinIn[SY_LOAD] = link.loadOutputsN;
  assign pinIn[SY_CLR]  = link.asyncZeroAllN;

  // Two-stage synchronisers for every link pin
  genvar g;
  generate
    for (g = 0; g < SY_W; g++) begin : gSync
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          syncA_q[g] <= SY_RST[g];
          syncB_q[g] <= SY_RST[g];
        end else if (ce) begin
          syncA_q[g] <= pinIn[g];
          syncB_q[g] <= syncA_q[g];
        end
      end
    end
  endgenerate

  // Edge history of serial clock and chip select
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclkPrev_q <= 1'b0;
      csPrev_q   <= 1'b1;
    end else if (ce) begin
      sclkPrev_q <= syncB_q[SY_SCLK];
      csPrev_q   <= syncB_q[SY_CS];
    end
  end

  assign csLow    = ~syncB_q[SY_CS];
  assign sclkRise = syncB_q[SY_SCLK] & ~sclkPrev_q & csLow;
  assign csRise   = syncB_q[SY_CS] & ~csPrev_q;
  assign clearNow = ~syncB_q[SY_CLR];
  assign loadLow  = ~syncB_q[SY_LOAD];
  assign hwShutdown = syncB_q[SY_PDR];

  // Shift register, newest bit at the bottom
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else if (ce && sclkRise) begin
      shift_q <= {shift_q[WORD_BITS-2:0], syncB_q[SY_SDI]};
    end
  end

  // Bits seen in this frame, saturating
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bitCnt_q <= CNT_ZERO;
    end else if (ce) begin
      if (csRise) begin
        bitCnt_q <= CNT_ZERO;
      end else if (sclkRise && bitCnt_q != CNT_FRAME) begin
        bitCnt_q <= bitCnt_q + CNT_ONE;
      end
    end
  end

  // Frame ends: decode the held word
  assign wordOk     = csRise & (bitCnt_q >= CNT_WORD);
  assign target     = chanOneHot(shift_q);
  assign sdFirstOn  = ~shift_q[SD_FIRST];
  assign sdSecondOn = ~shift_q[SD_SECOND];

  // Input registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      inReg_q <= '0;
    end else if (ce) begin
      if (clearNow) begin
        inReg_q <= '0;
      end else if (wordOk) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (target[i]) begin
            inReg_q[i] <= shift_q[DATA_MSB:0];
          end
        end
      end
    end
  end

  // Software shutdown state per channel
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      swShut_q <= '0;
    end else if (ce && wordOk) begin
      if (sdFirstOn && sdSecondOn) begin
        swShut_q <= '1;
      end else if (sdFirstOn || sdSecondOn) begin
        swShut_q <= swShut_q | target;
      end else begin
        swShut_q <= swShut_q & ~target;
      end
    end
  end

  assign anyShut = swShut_q | {NUM_CH{hwShutdown}};

  // DAC registers, one per channel
  generate
    for (g = 0; g < NUM_CH; g++) begin : gDac
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          dacReg_q[g] <= '0;
        end else if (ce) begin
          if (clearNow) begin
            dacReg_q[g] <= '0;
          end else if (loadLow && !anyShut[g]) begin
            dacReg_q[g] <= inReg_q[g];
          end
        end
      end
    end
  endgenerate

  // Word report for the user side
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lastWord_q   <= '0;
      wordStrobe_q <= 1'b0;
      shortFrame_q <= 1'b0;
    end else if (ce) begin
      wordStrobe_q <= wordOk;
      shortFrame_q <= csRise & ~wordOk;
      if (wordOk) begin
        lastWord_q <= shift_q;
      end
    end
  end

  assign dacCode     = dacReg_q;
  assign inputCode   = inReg_q;
  assign analogOutEn = ~anyShut;
  assign swShutdown  = swShut_q;
  assign lastWord    = lastWord_q;
  assign wordStrobe  = wordStrobe_q;
  assign shortFrame  = shortFrame_q;
endmodule

// ### hdl/qdac_pkg.sv
package qdac_pkg;
  // Word, code and channel sizes
  localparam int WORD_BITS  = 12;
  localparam int CODE_BITS  = 8;
  localparam int NUM_CH     = 4;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W      = 5;
  localparam int HALF_W     = 8;
  localparam int CODE_STEPS = 256;

  typedef logic [CODE_BITS-1:0]  qdac_byte_t;
  typedef qdac_byte_t [NUM_CH-1:0] qdac_code_t;
  typedef logic [WORD_BITS-1:0]  qdac_word_t;
  typedef logic [FRAME_BITS-1:0] qdac_frame_t;

  // Field positions inside the serial word
  localparam int SEL_HI_POS  = 11;
  localparam int SEL_LO_POS  = 10;
  localparam int SD_FIRST    = 9;
  localparam int SD_SECOND   = 8;
  localparam int DATA_MSB    = 7;
  localparam int FRAME_MSB   = FRAME_BITS - 1;
  localparam int WORD_PAD    = FRAME_BITS - WORD_BITS;

  // Synchroniser lanes and their idle values
  localparam int SY_SCLK  = 0;
  localparam int SY_CS    = 1;
  localparam int SY_SDI   = 2;
  localparam int SY_PDR   = 3;
  localparam int SY_LOAD  = 4;
  localparam int SY_CLR   = 5;
  localparam int SY_W     = 6;
  localparam logic [SY_W-1:0] SY_RST = 6'h32;

  localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
  localparam logic [CNT_W-1:0] CNT_WORD  = 5'h0c;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
  localparam logic [HALF_W-1:0] HALF_ZERO = 8'h00;
  localparam logic [HALF_W-1:0] HALF_ONE  = 8'h01;

  // Serial clock timing made by the host end
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SCLK_PERIOD_NS = 200;
  localparam int SCLK_HALF_CYC  =
    (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(SCLK_HALF_CYC - 1);
endpackage

// ### hdl/qdac_if.sv
`timescale 1ns/1ps
interface qdac_if;
  logic sclk;
  logic csN;
  logic sdi;
  logic powerDownReq;
  logic loadOutputsN;
  logic asyncZeroAllN;

  modport device (
    input sclk,
    input csN,
    input sdi,
    input powerDownReq,
    input loadOutputsN,
    input asyncZeroAllN
  );

  modport host (
    output sclk,
    output csN,
    output sdi,
    output powerDownReq,
    output loadOutputsN,
    output asyncZeroAllN
  );
endinterface

// ### hdl/qdac_host.sv
`timescale 1ns/1ps
module qdac_host (
  // Clock, reset, enable
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // Serial link
  qdac_if.host                      link,
  // Transfer request
  input  wire logic                 start,
  input  wire qdac_pkg::qdac_word_t txWord,
  input  wire logic                 byteMode,
  // Static controls
  input  wire logic                 powerDown,
  input  wire logic                 loadOutputsN,
  input  wire logic                 zeroAllN,
  // Status
  output logic                      busy,
  output logic                      done
);
  import qdac_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_TAIL, H_GAP} qdac_hstate_t;

  qdac_hstate_t     state_q;
  logic [HALF_W-1:0] half_q;
  logic             tick;
  logic             sclk_q;
  logic             csN_q;
  qdac_frame_t      out_q;
  logic [CNT_W-1:0] left_q;
  logic             done_q;
  logic             pdr_q;
  logic             load_q;
  logic             zero_q;

  assign tick = (half_q == HALF_LAST);

  // Half-period divider for the serial clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      half_q <= HALF_ZERO;
    end else if (ce) begin
      if (state_q == H_IDLE || tick) begin
        half_q <= HALF_ZERO;
      end else begin
        half_q <= half_q + HALF_ONE;
      end
    end
  end

  // Frame sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= H_IDLE;
      sclk_q  <= 1'b0;
      csN_q   <= 1'b1;
      out_q   <= '0;
      left_q  <= CNT_ZERO;
      done_q  <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          if (start) begin
            csN_q   <= 1'b0;
            sclk_q  <= 1'b0;
            state_q <= H_SHIFT;
            if (byteMode) begin
              out_q  <= {{WORD_PAD{1'b0}}, txWord};
              left_q <= CNT_FRAME;
            end else begin
              out_q  <= {txWord, {WORD_PAD{1'b0}}};
              left_q <= CNT_WORD;
            end
          end
        end
        H_SHIFT: begin
          if (tick) begin
            if (!sclk_q) begin
              sclk_q <= 1'b1;
            end else begin
              sclk_q <= 1'b0;
              if (left_q == CNT_ONE) begin
                state_q <= H_TAIL;
              end else begin
                out_q  <= {out_q[FRAME_MSB-1:0], 1'b0};
                left_q <= left_q - CNT_ONE;
              end
            end
          end
        end
        H_TAIL: begin
          if (tick) begin
            csN_q   <= 1'b1;
            state_q <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            done_q  <= 1'b1;
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Static control pins, registered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pdr_q  <= 1'b0;
      load_q <= 1'b0;
      zero_q <= 1'b1;
    end else if (ce) begin
      pdr_q  <= powerDown;
      load_q <= loadOutputsN;
      zero_q <= zeroAllN;
    end
  end

  assign link.sclk          = sclk_q;
  assign link.csN           = csN_q;
  assign link.sdi           = out_q[FRAME_MSB];
  assign link.powerDownReq  = pdr_q;
  assign link.loadOutputsN  = load_q;
  assign link.asyncZeroAllN = zero_q;
  assign busy = (state_q != H_IDLE);
  assign done = done_q;
endmodule

// ### sim/qdac_link_properties.sv
`timescale 1ns/1ps
module qdac_link_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link wires
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic powerDownReq,
  input wire logic loadOutputsN,
  input wire logic asyncZeroAllN
);
  logic       sclkQ;
  logic [4:0] riseCnt;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclkQ <= 1'b0;
    end else begin
      sclkQ <= sclk;
    end
  end

  // Serial clock rises within the current frame
  always_ff @(posedge clock) begin
    if (!rst_n || csN) begin
      riseCnt <= 5'h00;
    end else if (sclk && !sclkQ) begin
      riseCnt <= riseCnt + 5'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  reset_idle_a: assert property (
    $rose(rst_n) |-> csN && !sclk && asyncZeroAllN && !loadOutputsN)
    else $error("link not idle after reset");
  idle_clock_low_a: assert property (csN |-> !sclk)
    else $error("serial clock moved outside frame");
  data_steady_a: assert property (sclk |-> $stable(sdi))
    else $error("data moved while serial clock high");
  high_length_a: assert property (
    $rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  low_length_a: assert property ($fell(sclk) && !csN |-> !sclk [*4])
    else $error("serial clock low phase short");
  select_setup_a: assert property ($fell(csN) |-> !sclk [*4] ##1 sclk)
    else $error("first clock rise misplaced");
  frame_gap_a: assert property ($rose(csN) |-> csN [*3])
    else $error("select high gap too short");
  word_length_a: assert property (
    $rose(csN) |-> riseCnt == 5'h0c || riseCnt == 5'h10)
    else $error("frame bit count wrong");
  data_on_fall_a: assert property (
    !csN && !$past(csN) && $changed(sdi) |-> $fell(sclk))
    else $error("data changed off the falling clock");
  frame_ends_a: assert property ($fell(csN) |-> ##[90:140] $rose(csN))
    else $error("frame did not end in time");

  cover property ($rose(csN) && riseCnt == 5'h0c);
  cover property ($rose(csN) && riseCnt == 5'h10);
  cover property ($rose(powerDownReq));
  cover property ($fell(asyncZeroAllN));
  cover property ($rose(loadOutputsN));
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import qdac_pkg::*;
  logic              clock, rst_n, start, byteMode, powerDown, loadOutputsN, zeroAllN;
  logic              hwShutdown, wordStrobe, shortFrame, busy, done;
  qdac_word_t        txWord, lastWord;
  qdac_code_t        dacCode, inputCode, expIn, expDac;
  logic [NUM_CH-1:0] analogOutEn, swShutdown;
  int                num_errors = 0;
  int                n_compared = 0;
  int                nStrobe = 0;
  int                nShort = 0;
  int                nWords = 0;
  logic              ce;

  qdac_if lnk ();
  qdac_host u_qdac_host (.clock(clock), .rst_n(rst_n), .ce(ce), .link(lnk.host),
    .start(start), .txWord(txWord), .byteMode(byteMode), .powerDown(powerDown),
    .loadOutputsN(loadOutputsN), .zeroAllN(zeroAllN), .busy(busy), .done(done));
  qdac_dev u_qdac_dev (.clock(clock), .rst_n(rst_n), .ce(ce), .link(lnk.device),
    .dacCode(dacCode), .inputCode(inputCode), .analogOutEn(analogOutEn),
    .swShutdown(swShutdown), .hwShutdown(hwShutdown), .lastWord(lastWord),
    .wordStrobe(wordStrobe), .shortFrame(shortFrame));
  qdac_link_properties u_qdac_link_properties (.clock(clock), .rst_n(rst_n),
    .sclk(lnk.sclk), .csN(lnk.csN), .sdi(lnk.sdi), .powerDownReq(lnk.powerDownReq),
    .loadOutputsN(lnk.loadOutputsN), .asyncZeroAllN(lnk.asyncZeroAllN));

  // Count report pulses away from the clock edge
  always @(negedge clock) begin
    if (wordStrobe === 1'b1) begin
      nStrobe++;
    end
    if (shortFrame === 1'b1) begin
      nShort++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One whole frame, then time for the device to decode it
  task automatic wr(input logic [1:0] ch, input logic [1:0] sd, input qdac_byte_t code,
                    input logic bm);
    int i;
    @(posedge clock);
    start <= 1'b1;
    txWord <= {ch, sd, code};
    byteMode <= bm;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    chk(32'(busy), 32'h1);
    for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clock);
    chk(32'(done), 32'h1);
    chk(32'(busy), 32'h0);
    ticks(8);
    expIn[ch] = code;
    nWords++;
    chk(32'(lastWord), 32'({ch, sd, code}));
    chk(inputCode, expIn);
    chk(32'(nStrobe), 32'(nWords));
    chk(32'(nShort), 32'h0);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    txWord = '0;
    byteMode = 1'b0;
    powerDown = 1'b0;
    loadOutputsN = 1'b0;
    zeroAllN = 1'b1;
    ce = 1'b1;
    expIn = '0;
    expDac = '0;
    ticks(16);
    rst_n <= 1'b1;
    ticks(4);
    chk(dacCode, 32'h0);
    chk(inputCode, 32'h0);
    chk(32'(analogOutEn), 32'hf);
    $display("test reset done");
    for (int c = 0; c < NUM_CH; c++) begin
      wr(2'(c), 2'b11, 8'h3c + 8'(c * 17), 1'(c));
      expDac[c] = expIn[c];
      chk(dacCode, expDac);
    end
    $display("test channel writes done");
    loadOutputsN <= 1'b1;
    wr(2'd2, 2'b11, 8'hc3, 1'b0);
    wr(2'd0, 2'b11, 8'h5a, 1'b1);
    chk(dacCode, expDac);
    loadOutputsN <= 1'b0;
    ticks(6);
    expDac = expIn;
    chk(dacCode, expDac);
    $display("test load strobe done");
    wr(2'd1, 2'b01, 8'h77, 1'b0);
    chk(32'(swShutdown), 32'h2);
    chk(32'(analogOutEn), 32'hd);
    chk(dacCode, expDac);
    wr(2'd3, 2'b10, 8'h99, 1'b1);
    chk(32'(swShutdown), 32'ha);
    chk(dacCode, expDac);
    wr(2'd0, 2'b00, 8'h01, 1'b0);
    chk(32'(swShutdown), 32'hf);
    chk(32'(analogOutEn), 32'h0);
    chk(dacCode, expDac);
    for (int c = 0; c < NUM_CH; c++) begin
      wr(2'(c), 2'b11, 8'h40 + 8'(c), 1'b0);
    end
    expDac = expIn;
    chk(32'(swShutdown), 32'h0);
    chk(dacCode, expDac);
    $display("test soft shutdown done");
    powerDown <= 1'b1;
    ticks(6);
    chk(32'(hwShutdown), 32'h1);
    chk(32'(analogOutEn), 32'h0);
    wr(2'd2, 2'b11, 8'he1, 1'b1);
    chk(dacCode, expDac);
    powerDown <= 1'b0;
    ticks(6);
    expDac = expIn;
    chk(dacCode, expDac);
    chk(32'(analogOutEn), 32'hf);
    $display("test hard shutdown done");
    // Clear pulse while both ends are frozen must not reach the registers
    ce <= 1'b0;
    zeroAllN <= 1'b0;
    ticks(6);
    zeroAllN <= 1'b1;
    ticks(2);
    ce <= 1'b1;
    ticks(6);
    chk(inputCode, expIn);
    chk(dacCode, expDac);
    $display("test clock enable done");
    zeroAllN <= 1'b0;
    ticks(8);
    chk(inputCode, 32'h0);
    chk(dacCode, 32'h0);
    zeroAllN <= 1'b1;
    ticks(4);
    $display("test clear done");
    tally_and_finish();
  end
endmodule
